// *** logic/mtv_pkg.sv ***
// Purpose: shared constants and types for the tag value map
// Assumes: 16-bit holding registers, tag word area and diagnostic area
// Notes:   offsets are zero-based holding register offsets
package mtv_pkg;

    localparam int NUM_TAGS = 500;
    localparam int NUM_TAG_WORDS = 1001;
    localparam int NUM_DIAG_REGS = 32;
    localparam logic [15:0] TAG_AREA_FIRST = 16'h0000;
    localparam logic [15:0] TAG_AREA_LAST = 16'h03E8;
    localparam logic [15:0] DIAG_FLAGS_1_TO_16 = 16'h2328;
    localparam logic [15:0] DIAG_FLAGS_17_TO_32 = 16'h2329;
    localparam logic [15:0] DIAG_FLAGS_481_TO_496 = 16'h2347;
    localparam logic [15:0] DIAG_FLAGS_497_TO_500 = 16'h2348;
    localparam logic [15:0] DIAG_RESET = 16'h0000;
    localparam logic [7:0] FC_READ_HOLDING = 8'h03;
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam int HOLD_TIME_S = 10;
    localparam longint CLK_HZ = 200000000;
    localparam longint HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;
    localparam logic [31:0] FACTORY_IP = 32'hC0A85A65;
    localparam int DT_HOUR_POS = 8;
    localparam int DT_YEAR_POS = 9;
    localparam int YEAR_BASE = 2000;

    typedef enum logic [2:0] {
        TYPE_S16  = 3'h0,
        TYPE_U16  = 3'h1,
        TYPE_I32  = 3'h2,
        TYPE_F32_HWF = 3'h3,
        TYPE_F32_LWF = 3'h4,
        TYPE_U64  = 3'h5,
        TYPE_DT   = 3'h6
    } mtv_type_t;

    // value delivered by the polling engine
    typedef struct packed {
        logic [8:0]  tag;
        logic [9:0]  start_reg;
        mtv_type_t   dtype;
        logic [63:0] value;
        logic        timed_out;
    } mtv_tag_upd_t;

    // date/time fields as delivered
    typedef struct packed {
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [6:0] year_ofs;
        logic [3:0] month;
        logic [4:0] day;
    } mtv_datetime_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mtv_req_t;

    typedef struct packed {
        logic        valid;
        logic        exc;
        logic [7:0]  code;
        logic [15:0] rdata;
    } mtv_rsp_t;

endpackage : mtv_pkg

// *** logic/mtv_factory_reset.sv ***
// Purpose: switch-driven factory restore sequencer
// Assumes: switch bank arrives from pins, asynchronous to mclk_in
// Notes:   armed only when all switches were on at power-up
`timescale 1ns/1ps
`default_nettype none
module mtv_factory_reset #(
    parameter longint HOLD_CYCLES = mtv_pkg::HOLD_CYCLES
) (
    input  wire logic       mclk_in,      // system clock
    input  wire logic       srst_in,      // sync reset
    input  wire logic       clk_en_in,    // clock enable
    input  wire logic [1:0] switch_in,    // config_switch_bank 1..2
    output logic            restore_out,  // factory config commanded
    output logic            done_out      // hold time satisfied
);
    logic [1:0] sw_meta;
    logic [1:0] sw_sync;
    logic       sampled;
    logic       armed;
    logic [31:0] count;
    wire        all_on = &sw_sync;
    wire        hold_met = (count >= 32'(HOLD_CYCLES - 1));

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sw_meta <= 2'h0;
            sw_sync <= 2'h0;
        end else if (clk_en_in) begin
            sw_meta <= switch_in;
            sw_sync <= sw_meta;
        end
    end

    // sample strap after the synchroniser settles, once per power-up
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sampled     <= 1'b0;
            armed       <= 1'b0;
            count       <= 32'h0;
            restore_out <= 1'b0;
            done_out    <= 1'b0;
        end else if (clk_en_in) begin
            if (!sampled) begin
                sampled <= count[1];
                count   <= count + 32'h1;
                armed   <= all_on;
                if (count[1]) begin
                    count <= 32'h0;
                end
            end else if (armed && !done_out) begin
                count <= count + 32'h1;
                if (hold_met) begin
                    done_out    <= 1'b1;
                    restore_out <= 1'b1;
                end
            end
        end
    end
endmodule // mtv_factory_reset
`default_nettype wire

// *** logic/mtv_tag_value_map.sv ***
// Purpose: holding-register presentation of converted meter tag values
// Assumes: one Modbus request at a time from the protocol front end
// Notes:   tag words packed at update time, read back as 16-bit words
`timescale 1ns/1ps
`default_nettype none
module mtv_tag_value_map #(
    parameter longint HOLD_CYCLES = mtv_pkg::HOLD_CYCLES
) (
    input  wire logic                 mclk_in,       // 200 MHz clock
    input  wire logic                 srst_in,       // sync reset, high
    input  wire logic                 clk_en_in,     // freezes state when low
    input  wire mtv_pkg::mtv_tag_upd_t upd_in,       // tag update data
    input  wire logic                 upd_valid_in,  // update strobe
    input  wire mtv_pkg::mtv_req_t    req_in,        // register request
    input  wire logic [1:0]           switch_in,     // config_switch_bank
    input  wire logic                 factory_ack_in,// config store reloaded
    output logic                      upd_ready_out, // update accepted
    output mtv_pkg::mtv_rsp_t         rsp_out,       // register answer
    output logic                      factory_restore_out, // restore command
    output logic                      factory_use_out,     // run factory cfg
    output logic [31:0]               factory_ip_out       // restored address
);
    logic [15:0] tag_words [mtv_pkg::NUM_TAG_WORDS];
    logic [15:0] diag [mtv_pkg::NUM_DIAG_REGS];
    logic        restore_req;
    logic        hold_done;
    logic        restore_pending;

    // update unpacking
    wire mtv_pkg::mtv_datetime_t dt = upd_in.value[31:0];
    wire [15:0] w0 = upd_in.value[63:48];
    wire [15:0] w1 = upd_in.value[47:32];
    wire [15:0] w2 = upd_in.value[31:16];
    wire [15:0] w3 = upd_in.value[15:0];
    wire [15:0] dt_hm = {dt.hours, dt.minutes};
    wire [15:0] dt_date = {dt.year_ofs, dt.month, dt.day};
    wire [9:0] base = upd_in.start_reg;
    wire upd_fire = upd_valid_in && upd_ready_out;
    wire [4:0] diag_idx = upd_in.tag[8:4];
    wire [3:0] diag_bit = upd_in.tag[3:0];

    function automatic logic [1:0] word_count(mtv_pkg::mtv_type_t t);
        unique case (t)
            mtv_pkg::TYPE_S16, mtv_pkg::TYPE_U16: word_count = 2'd0;
            mtv_pkg::TYPE_U64:                    word_count = 2'd3;
            default:                              word_count = 2'd1;
        endcase
    endfunction

    // returns the k-th register word for the tag type
    function automatic logic [15:0] pick(mtv_pkg::mtv_type_t t,
                                         logic [1:0] k);
        logic [15:0] r;
        r = w3;
        unique case (t)
            mtv_pkg::TYPE_U64: begin
                r = (k == 2'd0) ? w0 : (k == 2'd1) ? w1 :
                    (k == 2'd2) ? w2 : w3;
            end
            mtv_pkg::TYPE_I32,
            mtv_pkg::TYPE_F32_HWF: begin
                r = (k == 2'd0) ? w2 : w3;
            end
            mtv_pkg::TYPE_F32_LWF: begin
                r = (k == 2'd0) ? w3 : w2;
            end
            mtv_pkg::TYPE_DT: begin
                r = (k == 2'd0) ? dt_hm : dt_date;
            end
            default: r = w3;
        endcase
        return r;
    endfunction

    wire [1:0] last_k = word_count(upd_in.dtype);
    wire fits = (11'(base) + 11'(last_k)) <= 11'(mtv_pkg::TAG_AREA_LAST);
    wire tag_ok = upd_in.tag < 9'(mtv_pkg::NUM_TAGS);

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            upd_ready_out <= 1'b0;
        end else if (clk_en_in) begin
            upd_ready_out <= 1'b1;
        end
    end

    // tag words carry no reset: contents defined by the first update
    always_ff @(posedge mclk_in) begin
        if (clk_en_in && upd_fire && fits) begin
            for (int k = 0; k < 4; k++) begin
                if (2'(k) <= last_k) begin
                    tag_words[base + 10'(k)] <= pick(upd_in.dtype, 2'(k));
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            for (int i = 0; i < mtv_pkg::NUM_DIAG_REGS; i++) begin
                diag[i] <= mtv_pkg::DIAG_RESET;
            end
        end else if (clk_en_in && upd_fire && tag_ok) begin
            diag[diag_idx][diag_bit] <= upd_in.timed_out;
        end
    end

    // request decode
    wire is_read = req_in.func == mtv_pkg::FC_READ_HOLDING;
    wire is_write = req_in.func == mtv_pkg::FC_WRITE_SINGLE;
    wire in_tag = req_in.addr <= mtv_pkg::TAG_AREA_LAST;
    wire in_diag = (req_in.addr >= mtv_pkg::DIAG_FLAGS_1_TO_16) &&
                   (req_in.addr <= mtv_pkg::DIAG_FLAGS_497_TO_500);
    wire [15:0] diag_off = req_in.addr - mtv_pkg::DIAG_FLAGS_1_TO_16;
    wire [15:0] tag_rd = tag_words[req_in.addr[9:0]];
    // last diag offset lies past the flag array: reads as zero, no alias
    wire diag_hit = diag_off < 16'(mtv_pkg::NUM_DIAG_REGS);
    wire [15:0] diag_rd = diag_hit ? diag[diag_off[4:0]] : mtv_pkg::DIAG_RESET;
    wire func_bad = !(is_read || is_write);
    wire addr_bad = is_read ? !(in_tag || in_diag) : !in_tag;
    wire [15:0] rd_val = in_tag ? tag_rd : diag_rd;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rsp_out <= '0;
        end else if (clk_en_in) begin
            rsp_out.valid <= req_in.valid;
            rsp_out.exc   <= req_in.valid && (func_bad || addr_bad);
            rsp_out.code  <= func_bad ? mtv_pkg::EXC_ILLEGAL_FUNC :
                             addr_bad ? mtv_pkg::EXC_ILLEGAL_ADDR :
                             req_in.func;
            rsp_out.rdata <= is_write ? req_in.wdata : rd_val;
        end
    end

    mtv_factory_reset #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_factory (
        .mclk_in     (mclk_in),
        .srst_in     (srst_in),
        .clk_en_in   (clk_en_in),
        .switch_in   (switch_in),
        .restore_out (restore_req),
        .done_out    (hold_done)
    );

    // restore command held until the config store acknowledges
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            restore_pending     <= 1'b0;
            factory_restore_out <= 1'b0;
            factory_use_out     <= 1'b0;
            factory_ip_out      <= 32'h0;
        end else if (clk_en_in) begin
            if (restore_req && !restore_pending && hold_done) begin
                restore_pending     <= 1'b1;
                factory_restore_out <= 1'b1;
                factory_ip_out      <= mtv_pkg::FACTORY_IP;
            end else if (factory_ack_in) begin
                factory_restore_out <= 1'b0;
            end
            if (factory_ack_in) begin
                factory_use_out <= 1'b1;
            end
        end
    end
endmodule // mtv_tag_value_map
`default_nettype wire

// *** tb/mtv_tag_value_map_sva.sv ***
// Purpose: port checks for the tag value map
// Assumes: one clock, sync reset high
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module mtv_tag_value_map_sva (
    input wire logic              mclk_in,             // clock
    input wire logic              srst_in,             // reset
    input wire logic              clk_en_in,           // enable
    input wire mtv_pkg::mtv_req_t req_in,              // request
    input wire mtv_pkg::mtv_rsp_t rsp_out,             // answer
    input wire logic              factory_ack_in,      // store ack
    input wire logic              factory_restore_out, // restore
    input wire logic              factory_use_out,     // factory cfg
    input wire logic [31:0]       factory_ip_out       // address
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    wire take = req_in.valid && clk_en_in;
    wire rd = take && req_in.func == mtv_pkg::FC_READ_HOLDING;
    wire wr = take && req_in.func == mtv_pkg::FC_WRITE_SINGLE;
    wire in_diag = req_in.addr >= mtv_pkg::DIAG_FLAGS_1_TO_16
        && req_in.addr <= mtv_pkg::DIAG_FLAGS_497_TO_500;
    a_rsp_latency: assert property (take |=> rsp_out.valid)
        else $error("no answer one cycle after request");
    a_no_spurious: assert property (!req_in.valid && clk_en_in
        |=> !rsp_out.valid)
        else $error("answer without request");
    a_bad_func: assert property (take && !rd && !wr |=>
        rsp_out.exc && rsp_out.code == mtv_pkg::EXC_ILLEGAL_FUNC)
        else $error("unsupported function not refused");
    a_diag_readonly: assert property (wr && in_diag |=>
        rsp_out.exc && rsp_out.code == mtv_pkg::EXC_ILLEGAL_ADDR)
        else $error("diagnostic write not refused");
    a_reserved_addr: assert property (rd
        && req_in.addr > mtv_pkg::TAG_AREA_LAST
        && req_in.addr < mtv_pkg::DIAG_FLAGS_1_TO_16
        |=> rsp_out.exc && rsp_out.code == mtv_pkg::EXC_ILLEGAL_ADDR)
        else $error("reserved read not refused");
    a_tag_read_ok: assert property (rd
        && req_in.addr <= mtv_pkg::TAG_AREA_LAST |=> !rsp_out.exc)
        else $error("tag read refused");
    a_restore_ip: assert property (factory_restore_out |->
        factory_ip_out == mtv_pkg::FACTORY_IP)
        else $error("restore without factory address");
    a_ack_to_use: assert property (factory_restore_out
        && factory_ack_in && clk_en_in
        |=> factory_use_out && !factory_restore_out)
        else $error("ack did not select factory setup");
    a_use_sticky: assert property (factory_use_out |=> factory_use_out)
        else $error("factory use dropped");
endmodule // mtv_tag_value_map_sva
`default_nettype wire

// *** tb/mtv_master_model.sv ***
// Purpose: register master issuing holding register requests
// Assumes: slave answers one cycle after each request
// Notes:   one request per call, idle() releases the bus
`timescale 1ns/1ps
`default_nettype none
module mtv_master_model (
    input  wire logic            mclk_in, // clock
    output var mtv_pkg::mtv_req_t req_out  // request to slave
);
    initial req_out = '0;
    task automatic issue(input logic [7:0] f, input logic [15:0] a,
                         input logic [15:0] d);
        @(posedge mclk_in);
        req_out <= '{valid: 1'b1, func: f, addr: a, wdata: d};
    endtask
    // released fields flip so stale values are never mistaken
    task automatic idle();
        @(posedge mclk_in);
        req_out <= '{1'b0, ~req_out.func, ~req_out.addr, ~req_out.wdata};
    endtask
endmodule // mtv_master_model
`default_nettype wire

// *** tb/test_modbus_tag_value_map.sv ***
// Purpose: self-checking bench for the tag value map
// Assumes: hold time shortened to 20 cycles
// Notes:   answers checked against a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module test_modbus_tag_value_map;
    typedef struct packed {
        logic exc; logic [7:0] code; logic [15:0] rdata;
    } mtv_exp_t;
    logic mclk_in, srst_in, clk_en_in, upd_valid_in, factory_ack_in;
    logic [1:0] switch_in;
    mtv_pkg::mtv_tag_upd_t upd_in;
    mtv_pkg::mtv_req_t req_in;
    mtv_pkg::mtv_rsp_t rsp_out;
    logic upd_ready_out, factory_restore_out, factory_use_out;
    logic [31:0] factory_ip_out, seed = 32'h5067;
    logic [63:0] v;
    mtv_exp_t exp_q[$], e;
    int n_mismatch = 0, total_checks = 0, i;
    localparam logic [7:0] RD = mtv_pkg::FC_READ_HOLDING;
    localparam logic [7:0] WR = mtv_pkg::FC_WRITE_SINGLE;
    mtv_tag_value_map #(.HOLD_CYCLES(20)) mtv_tag_value_map_inst (
        .mclk_in(mclk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
        .upd_in(upd_in), .upd_valid_in(upd_valid_in), .req_in(req_in),
        .switch_in(switch_in), .factory_ack_in(factory_ack_in),
        .upd_ready_out(upd_ready_out), .rsp_out(rsp_out),
        .factory_restore_out(factory_restore_out),
        .factory_use_out(factory_use_out), .factory_ip_out(factory_ip_out));
    mtv_master_model mtv_master_model_inst (.mclk_in(mclk_in),
        .req_out(req_in));
    function logic [31:0] rnd();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] word_of(logic [2:0] t, logic [63:0] x,
                                            int k);
        case (t)
            mtv_pkg::TYPE_U64: return x[63-16*k -: 16];
            mtv_pkg::TYPE_F32_LWF: return k == 0 ? x[15:0] : x[31:16];
            mtv_pkg::TYPE_S16, mtv_pkg::TYPE_U16: return x[15:0];
            default: return k == 0 ? x[31:16] : x[15:0];
        endcase
    endfunction
    task automatic check(input string n, input logic [63:0] x,
                         input logic [63:0] g);
        total_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", n, x, g);
        end
    endtask
    task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                        input logic [15:0] d, input logic x, input logic [7:0] c);
        exp_q.push_back('{exc: x, code: c, rdata: d});
        mtv_master_model_inst.issue(f, a, d);
    endtask
    task automatic put(input logic [8:0] tg, input logic [9:0] s,
                       input logic [2:0] t, input logic [63:0] x, input logic o);
        @(posedge mclk_in);
        upd_in <= '{tg, s, mtv_pkg::mtv_type_t'(t), x, o};
        upd_valid_in <= 1'b1;
        @(posedge mclk_in);
        upd_valid_in <= 1'b0;
    endtask
    task complete_run();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (rsp_out.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] rsp_valid expected 0 seen 1");
            end else begin
                e = exp_q.pop_front();
                check("rsp_exc", e.exc, rsp_out.exc);
                if (e.exc) check("rsp_code", e.code, rsp_out.code);
                else check("rsp_rdata", e.rdata, rsp_out.rdata);
            end
        end
    end
    initial begin
        srst_in = 1'b1; clk_en_in = 1'b1; upd_valid_in = 1'b0;
        factory_ack_in = 1'b0; switch_in = 2'b11; upd_in = '0;
        repeat (6) @(posedge mclk_in);
        srst_in <= 1'b0;
        for (i = 0; i < 200 && factory_restore_out !== 1'b1; i++)
            @(posedge mclk_in);
        if (i == 200) begin
            n_mismatch++;
            $display("[FAIL] factory_restore expected 1 seen 0");
        end
        check("hold_time", 1, i >= 20);
        check("factory_ip", 32'hC0A85A65, factory_ip_out);
        @(posedge mclk_in) factory_ack_in <= 1'b1;
        @(posedge mclk_in) factory_ack_in <= 1'b0;
        @(posedge mclk_in);
        check("factory_use", 1, factory_use_out);
        srst_in <= 1'b1;
        switch_in <= 2'b00;
        repeat (6) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (60) @(posedge mclk_in);
        check("no_restore", 0, factory_restore_out);
        check("upd_ready", 1, upd_ready_out);
        for (int t = 0; t < 7; t++) begin
            v = {rnd(), rnd()};
            if (t == 6) v[63:28] = '0;
            put(9'd5, 10'h3E5, t[2:0], v, 1'b0);
            for (int k = 0; k < (t == 5 ? 4 : t < 2 ? 1 : 2); k++)
                xfer(RD, 16'(16'h03E5 + k), word_of(t[2:0], v, k), 0, 0);
            mtv_master_model_inst.idle();
        end
        put(9'd0, 10'h100, 3'd1, 64'(rnd()), 1'b1);
        put(9'd15, 10'h100, 3'd1, 64'(rnd()), 1'b1);
        put(9'd16, 10'h100, 3'd1, 64'(rnd()), 1'b1);
        put(9'd3, 10'h100, 3'd1, 64'(rnd()), 1'b0);
        xfer(RD, 16'h2328, 16'h8001, 0, 0);
        xfer(RD, 16'h2329, 16'h0001, 0, 0);
        xfer(8'h10, 16'h0000, 16'h0000, 1, 8'h01);
        xfer(WR, 16'h2328, 16'h1234, 1, 8'h02);
        xfer(WR, 16'h0002, 16'hBEEF, 0, 0);
        xfer(RD, 16'h1000, 16'h0000, 1, 8'h02);
        mtv_master_model_inst.idle();
        put(9'd0, 10'h100, 3'd1, 64'(rnd()), 1'b0);
        xfer(RD, 16'h2328, 16'h8000, 0, 0);
        mtv_master_model_inst.idle();
        for (i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge mclk_in);
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("[FAIL] rsp_count expected 0 seen %0d", exp_q.size());
        end
        complete_run();
    end
endmodule // test_modbus_tag_value_map
bind mtv_tag_value_map mtv_tag_value_map_sva mtv_tag_value_map_sva_inst (
    .mclk_in(mclk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .req_in(req_in), .rsp_out(rsp_out), .factory_ack_in(factory_ack_in),
    .factory_restore_out(factory_restore_out),
    .factory_use_out(factory_use_out), .factory_ip_out(factory_ip_out));
`default_nettype wire
